// file: common/fap_pkg.sv
package fap_pkg;
  localparam int CLK_NS = 5;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int BANK_W = 4;
  localparam int NBANK = 2 ** BANK_W;
  localparam int SECT_W = 6;
  localparam int NSECT = 2 ** SECT_W;
  localparam int OFS_W = ADDR_W - BANK_W;
  // Command offsets within a bank
  localparam logic [OFS_W-1:0] UNL_OFS1 = 12'h555;
  localparam logic [OFS_W-1:0] UNL_OFS2 = 12'h2AA;
  // Command data
  localparam logic [DATA_W-1:0] D_UNL1 = 16'h00AA;
  localparam logic [DATA_W-1:0] D_UNL2 = 16'h0055;
  localparam logic [DATA_W-1:0] D_IDENT = 16'h0090;
  localparam logic [DATA_W-1:0] D_PROG = 16'h00A0;
  localparam logic [DATA_W-1:0] D_EXIT = 16'h00F0;
  localparam logic [DATA_W-1:0] D_SUSP = 16'h00B0;
  localparam logic [DATA_W-1:0] D_RESUME = 16'h0030;
  localparam logic [DATA_W-1:0] D_LOCKED = 16'h0001;
  localparam logic [DATA_W-1:0] D_UNLOCKED = 16'h0000;
  localparam logic [DATA_W-1:0] ERASED = 16'hFFFF;
  // Identification word offsets
  localparam logic [3:0] ID_MAKER = 4'h0;
  localparam logic [3:0] ID_DEV1 = 4'h1;
  localparam logic [3:0] ID_LOCK = 4'h2;
  localparam logic [3:0] ID_IND = 4'h3;
  localparam logic [3:0] ID_DEV2 = 4'hE;
  localparam logic [3:0] ID_DEV3 = 4'hF;
  // Indicator word fields
  localparam int IND_FACT = 7;
  localparam int IND_CUST = 6;
  localparam int IND_HS = 5;
  localparam int IND_WP_LO = 3;
  localparam logic IND_HS_STD = 1'b0;
  localparam logic [1:0] IND_WP_BOTH = 2'h0;
  // Timing
  localparam int PROG_TIME_NS = 10000;
  localparam int PROG_CYC = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_NS = 20;
  localparam int WE_CYC = (WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_NS = 20;
  localparam int RD_CYC = (RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int HRST_NS = 50;
  localparam int HRST_CYC = (HRST_NS + CLK_NS - 1) / CLK_NS;
  // Controller registers, byte offsets
  localparam logic [4:0] HR_CMD = 5'h00;
  localparam logic [4:0] HR_ADDR = 5'h04;
  localparam logic [4:0] HR_DATA = 5'h08;
  localparam logic [4:0] HR_RDATA = 5'h0C;
  localparam logic [4:0] HR_STAT = 5'h10;

  typedef enum logic [1:0] {CS_IDLE, CS_UNL1, CS_UNL2, CS_PSETUP} fap_cseq_t;
  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_PROGRAM, OP_IDENT, OP_EXIT, OP_HWRST
  } fap_op_t;
  typedef enum logic [2:0] {
    HP_IDLE, HP_ADDR, HP_WR, HP_WEND, HP_RD, HP_RST, HP_GAP
  } fap_hph_t;
endpackage

// file: common/fap_bus_if.sv
`timescale 1ns/1ps
interface fap_bus_if;
  logic ce_n;
  logic address_valid_n;
  logic we_n;
  logic oe_n;
  logic rst_n;
  logic rdy;
  logic [fap_pkg::ADDR_W-1:0] addr;
  logic [fap_pkg::DATA_W-1:0] dq_h;
  logic dq_h_oe_n;
  logic [fap_pkg::DATA_W-1:0] dq_d;
  logic dq_d_oe_n;
  logic [fap_pkg::DATA_W-1:0] dq;

  // Undriven bus reads as pulled high
  assign dq = !dq_d_oe_n ? dq_d : (!dq_h_oe_n ? dq_h : fap_pkg::ERASED);

  modport host (
    output ce_n, address_valid_n, we_n, oe_n, rst_n, addr, dq_h, dq_h_oe_n,
    input dq, rdy
  );
  modport dev (
    input ce_n, address_valid_n, we_n, oe_n, rst_n, addr, dq,
    output dq_d, dq_d_oe_n, rdy
  );
endinterface

// file: rtl/fap_array.sv
`timescale 1ns/1ps
module fap_array #(
  parameter int AW = fap_pkg::ADDR_W,
  parameter int DW = fap_pkg::DATA_W
) (
  // Clock
  input logic sys_clk,
  // Program port
  input logic wr_en,
  input logic [AW-1:0] wr_addr,
  input logic [DW-1:0] wr_data,
  // Read port
  input logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];

  if (AW < 1 || AW > 20 || DW < 1) begin : g_chk
    $error("fap_array: unsupported size");
  end

  // Array starts erased; no reset, it is storage not control
  initial begin
    for (int i = 0; i < 2 ** AW; i++) begin
      mem[i] = '1;
    end
  end

  // Programming only clears bits
  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= mem[wr_addr] & wr_data;
    end
  end

  assign rd_data = mem[rd_addr];
endmodule

// file: rtl/fap_dev.sv
// Functional notes
// - Entry: AA@555, 55@2AA, 90@555
// - Third write's top bits pick bank
// - Other banks still read array data
// - Entry only from read or suspend-read
// - Host never enters while program runs
// - Identification words by single reads only
// - F0 anywhere leaves identification mode
// - Offsets 00,01,0E,0F give id words
// - Sector plus 02 gives lock code
// - Offset 03 gives indicator bits
// - Host strobe levels for address, data
// - Sync address latch: first qualifying edge
// - Async address and data latch edges
// - Finished program returns bank to read
// - Programming ANDs old and new data
// - Busy: only suspend commands accepted
// - No identification while program runs
// - Hardware reset aborts program at once
// - Word program to any address order
// - Program: AA, 55, A0, data word
`timescale 1ns/1ps
module fap_dev #(
  parameter int PROG_CYC = fap_pkg::PROG_CYC,
  // Identification values are arbitrary
  parameter logic [fap_pkg::DATA_W-1:0] MAKER_ID = 16'h0A5A,
  parameter logic [fap_pkg::DATA_W-1:0] DEV_ID1 = 16'h1357,
  parameter logic [fap_pkg::DATA_W-1:0] DEV_ID2 = 16'h2468,
  parameter logic [fap_pkg::DATA_W-1:0] DEV_ID3 = 16'h3579
) (
  // Clock and reset
  input logic sys_clk,
  input logic nrst,
  // Flash bus
  fap_bus_if.dev bus,
  // Configuration
  input logic sync_mode,
  input logic [fap_pkg::NSECT-1:0] sect_lock,
  input logic factory_lock,
  input logic customer_lock,
  input logic [fap_pkg::NBANK-1:0] esusp_bank,
  // Status
  output logic busy,
  output logic prog_susp,
  output logic [fap_pkg::NBANK-1:0] ident_bank,
  output logic [fap_pkg::NBANK-1:0] esr_bank
);
  localparam int AW = fap_pkg::ADDR_W;
  localparam int DW = fap_pkg::DATA_W;
  localparam int BW = fap_pkg::BANK_W;
  localparam int PCW = $clog2(PROG_CYC + 1);
  localparam logic [PCW-1:0] PROG_LAST = PCW'(PROG_CYC - 1);

  if (PROG_CYC < 1) begin : g_chk
    $error("fap_dev: PROG_CYC must be at least 1");
  end

  typedef struct packed {
    logic ce_q;
    logic we_q;
    logic aval_q;
    logic alat;
    logic wact;
    logic [AW-1:0] addr;
    fap_pkg::fap_cseq_t seq;
    logic [fap_pkg::NBANK-1:0] ident;
    logic busy;
    logic susp;
    logic [PCW-1:0] cnt;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pdata;
    logic drive;
    logic [DW-1:0] rdata;
  } fap_dst_t;

  fap_dst_t st_r;
  fap_dst_t st_nxt;

  logic aval_fall;
  logic aval_rise;
  logic we_fall;
  logic we_rise;
  logic ce_rise;
  logic fire;
  logic rd_cyc;
  logic pdone;
  logic [AW-1:0] wa;
  logic [DW-1:0] wd;
  logic [BW-1:0] wbank;
  logic [BW-1:0] rbank;
  logic [fap_pkg::OFS_W-1:0] wofs;
  logic [DW-1:0] arr_q;
  logic [DW-1:0] id_q;

  function automatic logic [DW-1:0] id_word(
    input logic [AW-1:0] a,
    input logic [fap_pkg::NSECT-1:0] lk,
    input logic fl,
    input logic cl
  );
    logic [DW-1:0] w;
    w = '0;
    // Only the low offset bits and the sector bits matter
    case (a[3:0])
      fap_pkg::ID_MAKER: w = MAKER_ID;
      fap_pkg::ID_DEV1: w = DEV_ID1;
      fap_pkg::ID_DEV2: w = DEV_ID2;
      fap_pkg::ID_DEV3: w = DEV_ID3;
      fap_pkg::ID_LOCK: begin
        w = lk[a[AW-1 -: fap_pkg::SECT_W]] ? fap_pkg::D_LOCKED
                                           : fap_pkg::D_UNLOCKED;
      end
      fap_pkg::ID_IND: begin
        w[fap_pkg::IND_FACT] = fl;
        w[fap_pkg::IND_CUST] = cl;
        w[fap_pkg::IND_HS] = fap_pkg::IND_HS_STD;
        w[fap_pkg::IND_WP_LO +: 2] = fap_pkg::IND_WP_BOTH;
      end
      default: w = '0;
    endcase
    return w;
  endfunction

  assign aval_fall = st_r.aval_q && !bus.address_valid_n;
  assign aval_rise = !st_r.aval_q && bus.address_valid_n;
  assign we_fall = st_r.we_q && !bus.we_n;
  assign we_rise = !st_r.we_q && bus.we_n;
  assign ce_rise = !st_r.ce_q && bus.ce_n;
  // Data taken on whichever of WE or CE rises first
  assign fire = st_r.wact && (we_rise || ce_rise);
  assign rd_cyc = !bus.ce_n && !bus.oe_n && bus.we_n;
  assign pdone = st_r.busy && !st_r.susp && st_r.cnt == '0 && bus.rst_n;
  assign rbank = st_r.addr[AW-1 -: BW];
  assign id_q = id_word(st_r.addr, sect_lock, factory_lock, customer_lock);

  fap_array #(
    .AW(AW),
    .DW(DW)
  ) i_fap_array (
    .sys_clk(sys_clk),
    .wr_en(pdone),
    .wr_addr(st_r.paddr),
    .wr_data(st_r.pdata),
    .rd_addr(st_r.addr),
    .rd_data(arr_q)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.ce_q = bus.ce_n;
    st_nxt.we_q = bus.we_n;
    st_nxt.aval_q = bus.address_valid_n;
    wd = bus.dq;
    // A new address phase or end of access rearms the latch
    if (aval_fall || ce_rise) begin
      st_nxt.alat = 1'b0;
    end
    if (!bus.ce_n && !st_nxt.alat) begin
      if ((sync_mode && !bus.address_valid_n) || aval_rise || we_fall) begin
        st_nxt.addr = bus.addr;
        st_nxt.alat = 1'b1;
      end
    end
    wa = st_nxt.addr;
    wbank = wa[AW-1 -: BW];
    wofs = wa[fap_pkg::OFS_W-1:0];
    if (we_fall && !bus.ce_n) begin
      st_nxt.wact = 1'b1;
    end
    if (fire) begin
      st_nxt.wact = 1'b0;
    end
    // Embedded program timer; paused while suspended
    if (st_r.busy && !st_r.susp) begin
      if (pdone) begin
        st_nxt.busy = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt - 1'b1;
      end
    end
    if (fire) begin
      if (st_r.busy) begin
        // Everything but suspend and resume is dropped
        if (wd == fap_pkg::D_SUSP && !st_r.susp && !pdone) begin
          st_nxt.susp = 1'b1;
        end else if (wd == fap_pkg::D_RESUME && st_r.susp) begin
          st_nxt.susp = 1'b0;
        end
      end else if (wd == fap_pkg::D_EXIT) begin
        st_nxt.ident = '0;
        st_nxt.seq = fap_pkg::CS_IDLE;
      end else begin
        st_nxt.seq = fap_pkg::CS_IDLE;
        case (st_r.seq)
          fap_pkg::CS_IDLE: begin
            if (wd == fap_pkg::D_UNL1 && wofs == fap_pkg::UNL_OFS1) begin
              st_nxt.seq = fap_pkg::CS_UNL1;
            end
          end
          fap_pkg::CS_UNL1: begin
            if (wd == fap_pkg::D_UNL2 && wofs == fap_pkg::UNL_OFS2) begin
              st_nxt.seq = fap_pkg::CS_UNL2;
            end
          end
          fap_pkg::CS_UNL2: begin
            if (wofs == fap_pkg::UNL_OFS1 && wd == fap_pkg::D_IDENT) begin
              // Not busy here, so bank is in read or suspend-read
              st_nxt.ident[wbank] = 1'b1;
            end else if (wofs == fap_pkg::UNL_OFS1 &&
                         wd == fap_pkg::D_PROG) begin
              st_nxt.seq = fap_pkg::CS_PSETUP;
            end
          end
          fap_pkg::CS_PSETUP: begin
            // Any target address, no ordering kept
            st_nxt.paddr = wa;
            st_nxt.pdata = wd;
            st_nxt.busy = 1'b1;
            st_nxt.cnt = PROG_LAST;
          end
          default: st_nxt.seq = fap_pkg::CS_IDLE;
        endcase
      end
    end
    // One word per access at the latched address, no burst
    st_nxt.drive = rd_cyc;
    if (rd_cyc) begin
      st_nxt.rdata = (st_r.ident[rbank] && !st_r.busy) ? id_q
                                                       : arr_q;
    end
    // Reset pin drops the pending word; it is never written
    if (!bus.rst_n) begin
      st_nxt.busy = 1'b0;
      st_nxt.susp = 1'b0;
      st_nxt.seq = fap_pkg::CS_IDLE;
      st_nxt.ident = '0;
      st_nxt.wact = 1'b0;
      st_nxt.drive = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.ce_q <= 1'b1;
      st_r.we_q <= 1'b1;
      st_r.aval_q <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.dq_d = st_r.rdata;
  assign bus.dq_d_oe_n = !st_r.drive;
  assign bus.rdy = !st_r.busy;
  assign busy = st_r.busy;
  assign prog_susp = st_r.susp;
  assign ident_bank = st_r.ident;
  // Banks with a suspended erase that read array in that mode
  assign esr_bank = esusp_bank & ~st_r.ident;
endmodule

// file: rtl/fap_host.sv
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module fap_host #(
  parameter int WE_CYC = fap_pkg::WE_CYC,
  parameter int RD_CYC = fap_pkg::RD_CYC,
  parameter int HRST_CYC = fap_pkg::HRST_CYC
) (
  // Clock and reset
  input logic sys_clk,
  input logic nrst,
  // Flash bus
  fap_bus_if.host bus,
  // Avalon-MM slave
  input logic [4:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int AW = fap_pkg::ADDR_W;
  localparam int DW = fap_pkg::DATA_W;

  if (WE_CYC < 1 || WE_CYC > 255 || RD_CYC < 3 || RD_CYC > 255 ||
      HRST_CYC < 1 || HRST_CYC > 255) begin : g_chk
    $error("fap_host: timing count out of range");
  end

  typedef struct packed {
    fap_pkg::fap_hph_t ph;
    fap_pkg::fap_op_t op;
    logic [1:0] step;
    logic [7:0] tmr;
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
    logic [DW-1:0] rdata;
    logic ce_n;
    logic aval_n;
    logic we_n;
    logic oe_n;
    logic rst_n;
    logic dq_oe_n;
    logic [AW-1:0] baddr;
    logic [DW-1:0] dqo;
    logic rd_pend;
    logic [31:0] rdd;
  } fap_hst_t;

  fap_hst_t st_r;
  fap_hst_t st_nxt;
  fap_pkg::fap_op_t wop;
  logic cmd_ok;
  logic cmd_take;

  // Address and data of one bus write within a sequence
  function automatic logic [AW+DW-1:0] step_ad(
    input fap_pkg::fap_op_t op,
    input logic [1:0] st,
    input logic [AW-1:0] a,
    input logic [DW-1:0] d
  );
    logic [AW-1:0] base;
    logic [AW-1:0] ra;
    logic [DW-1:0] rd;
    base = {a[AW-1 -: fap_pkg::BANK_W], {fap_pkg::OFS_W{1'b0}}};
    ra = a;
    rd = d;
    if (op == fap_pkg::OP_EXIT) begin
      rd = fap_pkg::D_EXIT;
    end else if (op == fap_pkg::OP_IDENT || op == fap_pkg::OP_PROGRAM) begin
      case (st)
        2'd0: begin
          ra = base | AW'(fap_pkg::UNL_OFS1);
          rd = fap_pkg::D_UNL1;
        end
        2'd1: begin
          ra = base | AW'(fap_pkg::UNL_OFS2);
          rd = fap_pkg::D_UNL2;
        end
        2'd2: begin
          ra = base | AW'(fap_pkg::UNL_OFS1);
          rd = (op == fap_pkg::OP_IDENT) ? fap_pkg::D_IDENT
                                         : fap_pkg::D_PROG;
        end
        default: ra = a;
      endcase
    end
    return {ra, rd};
  endfunction

  function automatic logic [1:0] last_step(input fap_pkg::fap_op_t op);
    case (op)
      fap_pkg::OP_PROGRAM: return 2'd3;
      fap_pkg::OP_IDENT: return 2'd2;
      default: return 2'd0;
    endcase
  endfunction

  assign wop = fap_pkg::fap_op_t'(avs_writedata[2:0]);
  // No entry or program sequence while the device is busy
  assign cmd_ok = st_r.ph == fap_pkg::HP_IDLE &&
                  (bus.rdy || !(wop == fap_pkg::OP_IDENT ||
                                wop == fap_pkg::OP_PROGRAM));
  assign cmd_take = avs_write && avs_address == fap_pkg::HR_CMD && cmd_ok;

  always_comb begin
    st_nxt = st_r;
    avs_waitrequest = 1'b0;
    st_nxt.rd_pend = 1'b0;
    if (avs_read && !st_r.rd_pend) begin
      avs_waitrequest = 1'b1;
      st_nxt.rd_pend = 1'b1;
      if (avs_address == fap_pkg::HR_ADDR) begin
        st_nxt.rdd = 32'(st_r.addr);
      end else if (avs_address == fap_pkg::HR_DATA) begin
        st_nxt.rdd = 32'(st_r.data);
      end else if (avs_address == fap_pkg::HR_RDATA) begin
        st_nxt.rdd = 32'(st_r.rdata);
      end else if (avs_address == fap_pkg::HR_STAT) begin
        st_nxt.rdd = {30'h0000_0000, bus.rdy,
                      st_r.ph != fap_pkg::HP_IDLE};
      end else begin
        st_nxt.rdd = 32'h0000_0000;
      end
    end
    if (avs_write) begin
      if (avs_address == fap_pkg::HR_ADDR) begin
        st_nxt.addr = avs_writedata[AW-1:0];
      end else if (avs_address == fap_pkg::HR_DATA) begin
        st_nxt.data = avs_writedata[DW-1:0];
      end else if (avs_address == fap_pkg::HR_CMD) begin
        avs_waitrequest = !cmd_ok;
      end
    end
    case (st_r.ph)
      fap_pkg::HP_IDLE: begin
        if (cmd_take && wop == fap_pkg::OP_HWRST) begin
          st_nxt.op = wop;
          st_nxt.rst_n = 1'b0;
          st_nxt.tmr = 8'(HRST_CYC - 1);
          st_nxt.ph = fap_pkg::HP_RST;
        end else if (cmd_take && avs_writedata[2:0] < 3'h5) begin
          st_nxt.op = wop;
          st_nxt.step = 2'd0;
          {st_nxt.baddr, st_nxt.dqo} = step_ad(wop, 2'd0, st_r.addr,
                                               st_r.data);
          st_nxt.ce_n = 1'b0;
          st_nxt.aval_n = 1'b0;
          st_nxt.ph = fap_pkg::HP_ADDR;
        end
      end
      fap_pkg::HP_ADDR: begin
        st_nxt.aval_n = 1'b1;
        if (st_r.op == fap_pkg::OP_READ) begin
          st_nxt.oe_n = 1'b0;
          st_nxt.tmr = 8'(RD_CYC - 1);
          st_nxt.ph = fap_pkg::HP_RD;
        end else begin
          st_nxt.we_n = 1'b0;
          st_nxt.dq_oe_n = 1'b0;
          st_nxt.tmr = 8'(WE_CYC - 1);
          st_nxt.ph = fap_pkg::HP_WR;
        end
      end
      fap_pkg::HP_WR: begin
        if (st_r.tmr == 8'h00) begin
          st_nxt.we_n = 1'b1;
          st_nxt.ph = fap_pkg::HP_WEND;
        end else begin
          st_nxt.tmr = st_r.tmr - 8'h01;
        end
      end
      fap_pkg::HP_WEND: begin
        st_nxt.ce_n = 1'b1;
        st_nxt.dq_oe_n = 1'b1;
        st_nxt.ph = fap_pkg::HP_GAP;
      end
      fap_pkg::HP_RD: begin
        if (st_r.tmr == 8'h00) begin
          st_nxt.rdata = bus.dq;
          st_nxt.oe_n = 1'b1;
          st_nxt.ce_n = 1'b1;
          st_nxt.ph = fap_pkg::HP_GAP;
        end else begin
          st_nxt.tmr = st_r.tmr - 8'h01;
        end
      end
      fap_pkg::HP_RST: begin
        if (st_r.tmr == 8'h00) begin
          st_nxt.rst_n = 1'b1;
          st_nxt.ph = fap_pkg::HP_GAP;
        end else begin
          st_nxt.tmr = st_r.tmr - 8'h01;
        end
      end
      fap_pkg::HP_GAP: begin
        if (st_r.step == last_step(st_r.op)) begin
          st_nxt.ph = fap_pkg::HP_IDLE;
        end else begin
          st_nxt.step = st_r.step + 2'd1;
          {st_nxt.baddr, st_nxt.dqo} = step_ad(st_r.op, st_r.step + 2'd1,
                                               st_r.addr, st_r.data);
          st_nxt.ce_n = 1'b0;
          st_nxt.aval_n = 1'b0;
          st_nxt.ph = fap_pkg::HP_ADDR;
        end
      end
      default: st_nxt.ph = fap_pkg::HP_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
      st_r.ce_n <= 1'b1;
      st_r.aval_n <= 1'b1;
      st_r.we_n <= 1'b1;
      st_r.oe_n <= 1'b1;
      st_r.rst_n <= 1'b1;
      st_r.dq_oe_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.ce_n = st_r.ce_n;
  assign bus.address_valid_n = st_r.aval_n;
  assign bus.we_n = st_r.we_n;
  assign bus.oe_n = st_r.oe_n;
  assign bus.rst_n = st_r.rst_n;
  assign bus.addr = st_r.baddr;
  assign bus.dq_h = st_r.dqo;
  assign bus.dq_h_oe_n = st_r.dq_oe_n;
  assign avs_readdata = st_r.rdd;
endmodule

// file: tb/fap_assertions.sv
`timescale 1ns/1ps
module fap_assertions #(
  parameter int PROG_CYC = fap_pkg::PROG_CYC
) (
  // Clock and reset
  input logic sys_clk,
  input logic nrst,
  // Host strobes
  input logic ce_n,
  input logic address_valid_n,
  input logic we_n,
  input logic oe_n,
  input logic rst_n,
  input logic [fap_pkg::ADDR_W-1:0] addr,
  input logic [fap_pkg::DATA_W-1:0] dq_h,
  input logic dq_h_oe_n,
  // Device side
  input logic dq_d_oe_n,
  input logic rdy
);
  logic rd_sel;
  logic we_q_r;
  logic susp_r;
  logic [15:0] busy_cnt_r;
  logic [15:0] busy_cnt_nxt;

  assign rd_sel = !oe_n && !ce_n;

  // Length of the current busy stretch; a suspend stops the count
  always_comb begin
    busy_cnt_nxt = busy_cnt_r + 16'h0001;
    if (rdy) busy_cnt_nxt = 16'h0000;
    else if (susp_r) busy_cnt_nxt = busy_cnt_r;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_cnt_r <= 16'h0000;
      we_q_r <= 1'b1;
      susp_r <= 1'b0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
      we_q_r <= we_n;
      // Suspend and resume words taken at write strobe rise while busy
      if (!rst_n) begin
        susp_r <= 1'b0;
      end else if (we_n && !we_q_r && !ce_n && !rdy) begin
        if (dq_h == fap_pkg::D_SUSP) susp_r <= 1'b1;
        else if (dq_h == fap_pkg::D_RESUME) susp_r <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_we_frame;
    !we_n |-> oe_n && !ce_n && dq_d_oe_n;
  endproperty
  a_we_frame: assert property (p_we_frame)
    else $error("write strobe outside a write frame");

  property p_aval_frame;
    !address_valid_n |-> !ce_n && oe_n && we_n;
  endproperty
  a_aval_frame: assert property (p_aval_frame)
    else $error("address phase with bad strobes");

  property p_rd_drive;
    !dq_d_oe_n |-> $past(rd_sel) || $past(rd_sel, 2);
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("device drives data outside a read");

  property p_rst_abort;
    !rst_n |=> rdy && dq_d_oe_n;
  endproperty
  a_rst_abort: assert property (p_rst_abort)
    else $error("flash reset did not stop the program");

  property p_busy_cause;
    $fell(rdy) |-> $past(ce_n) == 1'b0 || $past(ce_n, 2) == 1'b0
      || $past(ce_n, 3) == 1'b0;
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy without a preceding write");

  property p_busy_end;
    busy_cnt_r <= PROG_CYC + 2;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("program did not finish in time");

  property p_we_release;
    $rose(we_n) |=> ce_n && dq_h_oe_n;
  endproperty
  a_we_release: assert property (p_we_release)
    else $error("chip select not released after write strobe");

  property p_we_hold;
    !we_n && !$past(we_n) |-> $stable(dq_h) && $stable(addr) && !dq_h_oe_n;
  endproperty
  a_we_hold: assert property (p_we_hold)
    else $error("data moved while write strobe low");

  property p_aval_latch;
    $rose(address_valid_n) |-> $stable(addr) && !ce_n;
  endproperty
  a_aval_latch: assert property (p_aval_latch)
    else $error("address moved at address valid rise");

  property p_rst_pulse;
    $fell(rst_n) |-> (!rst_n) [*4] ##1 rst_n;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("flash reset pulse of wrong length");

  c_prog: cover property ($fell(rdy));
  c_read: cover property ($fell(dq_d_oe_n));
  c_rst: cover property ($fell(rst_n));
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: %h not %h", $time, g, e); end end
module testbench;
  // Arbitrary identification values
  localparam logic [15:0] MAKER = 16'h0A5A;
  localparam logic [15:0] DEV1 = 16'h1357;
  localparam logic [15:0] DEV2 = 16'h2468;
  localparam logic [15:0] DEV3 = 16'h3579;
  logic sys_clk;
  logic nrst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sync_mode;
  logic [fap_pkg::NSECT-1:0] sect_lock;
  logic factory_lock;
  logic customer_lock;
  logic [15:0] esusp_bank;
  logic busy;
  logic prog_susp;
  logic [15:0] ident_bank;
  logic [15:0] esr_bank;
  logic [31:0] rd;
  logic [15:0] id_ofs [4] = '{16'h0000, 16'h0001, 16'h000E, 16'h000F};
  logic [15:0] id_val [4] = '{MAKER, DEV1, DEV2, DEV3};
  int n_errors = 0;
  int num_checks = 0;

  fap_bus_if bus ();
  fap_host #(.HRST_CYC(4)) i_fap_host (.sys_clk(sys_clk), .nrst(nrst),
    .bus(bus), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  fap_dev #(.PROG_CYC(200), .MAKER_ID(MAKER), .DEV_ID1(DEV1),
    .DEV_ID2(DEV2), .DEV_ID3(DEV3)) i_fap_dev (.sys_clk(sys_clk),
    .nrst(nrst), .bus(bus), .sync_mode(sync_mode), .sect_lock(sect_lock),
    .factory_lock(factory_lock), .customer_lock(customer_lock),
    .esusp_bank(esusp_bank), .busy(busy), .prog_susp(prog_susp),
    .ident_bank(ident_bank), .esr_bank(esr_bank));
  fap_assertions #(.PROG_CYC(200)) i_fap_assertions (.sys_clk(sys_clk),
    .nrst(nrst), .ce_n(bus.ce_n), .we_n(bus.we_n),
    .address_valid_n(bus.address_valid_n),
    .oe_n(bus.oe_n), .rst_n(bus.rst_n), .addr(bus.addr), .dq_h(bus.dq_h),
    .dq_h_oe_n(bus.dq_h_oe_n), .dq_d_oe_n(bus.dq_d_oe_n), .rdy(bus.rdy));

  task complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // One Avalon transfer; a stalled request is held until taken
  task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 2000);
    if (n >= 2000) n_errors++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task poll(input int b, input logic v);
    int n;
    n = 0;
    do begin
      av(1'b0, fap_pkg::HR_STAT, 32'h0000_0000);
      n++;
    end while (rd[b] !== v && n < 500);
    if (n >= 500) n_errors++;
  endtask

  task cmd(input logic [2:0] op, input logic [15:0] a, input logic [15:0] d);
    av(1'b1, fap_pkg::HR_ADDR, {16'h0000, a});
    av(1'b1, fap_pkg::HR_DATA, {16'h0000, d});
    av(1'b1, fap_pkg::HR_CMD, {29'h0000_0000, op});
    poll(0, 1'b0);
  endtask

  task frd(input logic [15:0] a, input logic [15:0] e);
    cmd(3'h0, a, 16'h0000);
    av(1'b0, fap_pkg::HR_RDATA, 32'h0000_0000);
    `CHK(rd, {16'h0000, e})
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (50000) @(posedge sys_clk);
    n_errors++;
    complete_run;
  end

  initial begin
    nrst = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    sync_mode = 1'b0;
    sect_lock = 64'h0000_0000_0020_0000;
    factory_lock = 1'b1;
    customer_lock = 1'b0;
    esusp_bank = 16'h0008;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    // Same program pair in async then sync latching
    for (int m = 0; m < 2; m++) begin
      sync_mode <= m[0];
      cmd(3'h2, 16'h2010 ^ 16'(m), 16'h0035);
      poll(1, 1'b1);
      cmd(3'h2, 16'h2010 ^ 16'(m), 16'h0053);
      poll(1, 1'b1);
      frd(16'h2010 ^ 16'(m), 16'h0011);
    end
    cmd(3'h2, 16'h9F00, 16'h1234);
    cmd(3'h1, 16'h9555, fap_pkg::D_UNL1);
    cmd(3'h1, 16'h92AA, fap_pkg::D_UNL2);
    cmd(3'h1, 16'h9555, fap_pkg::D_IDENT);
    `CHK(ident_bank, 16'h0000)
    frd(16'h9000, 16'hFFFF);
    frd(16'h9F00, 16'hFFFF);
    cmd(3'h1, 16'h9000, fap_pkg::D_SUSP);
    `CHK({busy, prog_susp}, 2'b11)
    cmd(3'h1, 16'h9000, fap_pkg::D_RESUME);
    `CHK({busy, prog_susp}, 2'b10)
    poll(1, 1'b1);
    frd(16'h9F00, 16'h1234);
    cmd(3'h2, 16'h0004, 16'h00FF);
    poll(1, 1'b1);
    frd(16'h0004, 16'h00FF);
    cmd(3'h1, 16'h5555, fap_pkg::D_UNL1);
    cmd(3'h1, 16'h52AA, fap_pkg::D_UNL2);
    cmd(3'h1, 16'h5555, fap_pkg::D_IDENT);
    `CHK(ident_bank, 16'h0020)
    for (int i = 0; i < 4; i++) frd(16'h5000 | id_ofs[i], id_val[i]);
    frd(16'h5003, 16'h0080);
    frd(16'h57F2, fap_pkg::D_LOCKED);
    frd(16'h5C02, fap_pkg::D_UNLOCKED);
    frd(16'h2010, 16'h0011);
    cmd(3'h3, 16'h3000, 16'h0000);
    `CHK(ident_bank, 16'h0028)
    `CHK(esr_bank, 16'h0000)
    frd(16'h3001, DEV1);
    cmd(3'h4, 16'h0000, 16'h0000);
    `CHK(ident_bank, 16'h0000)
    `CHK(esr_bank, 16'h0008)
    frd(16'h5000, 16'hFFFF);
    // Wrong address on the second unlock write must not enter the mode
    cmd(3'h1, 16'h6555, fap_pkg::D_UNL1);
    cmd(3'h1, 16'h6123, fap_pkg::D_UNL2);
    cmd(3'h1, 16'h6555, fap_pkg::D_IDENT);
    `CHK(ident_bank, 16'h0000)
    cmd(3'h3, 16'h1000, 16'h0000);
    `CHK(ident_bank, 16'h0002)
    cmd(3'h2, 16'h7777, 16'h0000);
    `CHK(busy, 1'b1)
    cmd(3'h5, 16'h0000, 16'h0000);
    `CHK(busy, 1'b0)
    `CHK(ident_bank, 16'h0000)
    frd(16'h7777, 16'hFFFF);
    av(1'b0, 5'h14, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    complete_run;
  end
endmodule
